// File: tws_slave_tx.sv
// Two-wire slave transmitter with an AHB-Lite register slave.
//
// Notes on behaviour
// - Acknowledge own address only with ack enable.
// - Read bit enters transmit; write bit not here.
// - Own address plus read acked gives A8.
// - Lost arbitration then addressed for read gives B0.
// - Load byte, clear flag; ack enable selects last.
// - Data byte acknowledged by master gives B8.
// - Ack enable cleared sends one final byte.
// - Master not acknowledge gives C0, then unaddressed.
// - Master acknowledges last byte gives C8.
// - Unaddressed device ignores clocks, master reads ones.
// - Start request issues start once bus free.
// - Leaving C0/C8, recognition follows ack enable.
// - Ack enable zero isolates, bus still monitored.
// - Address still recognised while asleep.
// - Sleep match wakes and holds clock low.
// - Data register not updated by address bytes.
// - Own address upper seven bits, bit zero general call.
`include "tws_defines.svh"
module tws_slave_tx (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   input wire logic i_scl,
   output logic o_scl_out,
   output logic o_scl_oe_n,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe_n,
   input wire logic i_sleep,
   input wire logic i_arb_lost,
   output logic o_wake,
   output logic o_start_request
);
   import tws_pkg::*;

   tws_ctrl_type ctrl_reg; // Software control fields.
   logic flag_reg; // Step done flag.
   logic wcol_reg; // Write collision flag.
   logic [7:0] code_reg; // Last status code.
   logic [1:0] presc_reg; // Prescaler bits, stored only.
   logic [7:0] data_reg; // Byte to send.
   logic [7:0] own_reg; // Own address and general call enable.
   logic dp_active_reg; // A data phase is running.
   logic dp_done_reg; // The data phase ends at the next edge.
   tws_req_type req_reg; // Captured address phase.
   logic [31:0] rdata_reg; // Read data.
   logic [2:0] scl_sync_reg; // Clock pin synchroniser.
   logic [2:0] sda_sync_reg; // Data pin synchroniser.
   logic scl_reg; // Filtered clock level.
   logic sda_reg; // Filtered data level.
   logic scl_prev_reg; // Clock level one cycle back.
   logic sda_prev_reg; // Data level one cycle back.
   tws_state_type state_reg; // Serial engine state.
   logic [3:0] bit_cnt_reg; // Bit counter within a byte.
   logic [7:0] shift_reg; // Address in, data out.
   logic sda_drive_reg; // Pull data low.
   logic last_reg; // Byte in flight is the last one.
   logic acked_reg; // Master acknowledged the byte.
   logic bus_free_reg; // No frame on the bus.
   logic wake_reg; // Wake request toward the power logic.
   logic scl_rise; // Rising clock edge.
   logic scl_fall; // Falling clock edge.
   logic start_seen; // Start condition.
   logic stop_seen; // Stop condition.
   logic addr_match; // Received address hits this device.
   logic set_evt; // Serial engine raises the flag now.
   logic [7:0] set_code; // Code that goes with it.
   logic bus_wr; // Register write in this cycle.
   logic flag_clear; // Software writes one to the flag.
   logic [7:0] wbyte; // Written byte.

   // Pins: the change counts once the second and third stages agree.
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         scl_sync_reg <= 3'h7;
         sda_sync_reg <= 3'h7;
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         scl_sync_reg <= {scl_sync_reg[1:0], i_scl};
         sda_sync_reg <= {sda_sync_reg[1:0], i_sda};
         if (scl_sync_reg[1] == scl_sync_reg[2]) begin
            scl_reg <= scl_sync_reg[2];
         end
         if (sda_sync_reg[1] == sda_sync_reg[2]) begin
            sda_reg <= sda_sync_reg[2];
         end
         scl_prev_reg <= scl_reg;
         sda_prev_reg <= sda_reg;
      end
   end

   // Edges and bus conditions seen from the filtered levels.
   assign scl_rise = scl_reg & ~scl_prev_reg;
   assign scl_fall = ~scl_reg & scl_prev_reg;
   assign start_seen = scl_reg & scl_prev_reg & sda_prev_reg & ~sda_reg;
   assign stop_seen = scl_reg & scl_prev_reg & ~sda_prev_reg & sda_reg;
   // Recognition uses the live ack enable, so clearing it isolates at once.
   assign addr_match = ctrl_reg.ack_enable & ctrl_reg.iface_enable & shift_reg[0] &
                       ((shift_reg[7:1] == own_reg[7:1]) | ((shift_reg[7:1] == 7'h00) & own_reg[0]));

   // Flag events of the serial engine and their status codes.
   always_comb begin
      set_evt = 1'b0;
      set_code = `TWS_ST_NO_INFO;
      if (state_reg == ST_ADDR_ACK && scl_fall) begin
         set_evt = 1'b1;
         set_code = i_arb_lost ? `TWS_ST_ARB_SLA_R : `TWS_ST_SLA_R_ACK;
      end else if (state_reg == ST_TX_ACK && scl_fall) begin
         set_evt = 1'b1;
         if (!acked_reg) begin
            set_code = `TWS_ST_DATA_NACK;
         end else if (last_reg) begin
            set_code = `TWS_ST_LAST_ACK;
         end else begin
            set_code = `TWS_ST_DATA_ACK;
         end
      end
   end

   // Serial engine.
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_reg <= ST_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         sda_drive_reg <= 1'b0;
         last_reg <= 1'b0;
         acked_reg <= 1'b0;
      end else if (!ctrl_reg.iface_enable) begin
         // A disabled interface releases both lines and forgets the frame.
         state_reg <= ST_IDLE;
         sda_drive_reg <= 1'b0;
      end else if (start_seen && state_reg != ST_TX_HOLD) begin
         // Start or repeated start: listen to a fresh address byte.
         state_reg <= ST_ADDR;
         bit_cnt_reg <= 4'h0;
         sda_drive_reg <= 1'b0;
      end else if (stop_seen && state_reg != ST_TX_HOLD && state_reg != ST_END_HOLD) begin
         state_reg <= ST_IDLE;
         sda_drive_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            ST_IDLE, ST_IGNORE: begin
               // Unaddressed: nothing driven, clocks ignored.
               sda_drive_reg <= 1'b0;
            end
            ST_ADDR: begin
               // Address bits are shifted privately, the data register stays.
               if (scl_rise && bit_cnt_reg != `TWS_ADDR_BITS) begin
                  shift_reg <= {shift_reg[6:0], sda_reg};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end else if (scl_fall && bit_cnt_reg == `TWS_ADDR_BITS) begin
                  if (addr_match) begin
                     state_reg <= ST_ADDR_ACK;
                     sda_drive_reg <= 1'b1;
                  end else begin
                     state_reg <= ST_IGNORE;
                  end
               end
            end
            ST_ADDR_ACK: begin
               // Acknowledge bit ends at the falling edge, then wait for software.
               if (scl_fall) begin
                  sda_drive_reg <= 1'b0;
                  state_reg <= ST_TX_HOLD;
               end
            end
            ST_TX_HOLD: begin
               // Clock held low until the flag is cleared with a byte loaded.
               if (!flag_reg) begin
                  shift_reg <= data_reg;
                  last_reg <= ~ctrl_reg.ack_enable;
                  sda_drive_reg <= ~data_reg[7];
                  bit_cnt_reg <= 4'h0;
                  state_reg <= ST_TX_BITS;
               end
            end
            ST_TX_BITS: begin
               // Next bit goes out on each falling edge.
               if (scl_fall) begin
                  if (bit_cnt_reg == `TWS_BYTE_LAST) begin
                     sda_drive_reg <= 1'b0;
                     state_reg <= ST_TX_ACK;
                  end else begin
                     shift_reg <= {shift_reg[6:0], 1'b1};
                     sda_drive_reg <= ~shift_reg[6];
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end
               end
            end
            ST_TX_ACK: begin
               // Master's answer is sampled high, acted on at the falling edge.
               if (scl_rise) begin
                  acked_reg <= ~sda_reg;
               end else if (scl_fall) begin
                  state_reg <= (acked_reg && !last_reg) ? ST_TX_HOLD : ST_END_HOLD;
               end
            end
            ST_END_HOLD: begin
               // Already unaddressed; leaves for good once the flag is cleared.
               if (!flag_reg) begin
                  state_reg <= ST_IGNORE;
               end
            end
         endcase
      end
   end

   // Bus free tracking for the start request.
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         bus_free_reg <= 1'b1;
      end else if (start_seen) begin
         bus_free_reg <= 1'b0;
      end else if (stop_seen) begin
         bus_free_reg <= 1'b1;
      end
   end

   // Wake request raised by a match while asleep, held until the flag clears.
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wake_reg <= 1'b0;
      end else if (state_reg == ST_ADDR && scl_fall && bit_cnt_reg == `TWS_ADDR_BITS && addr_match && i_sleep) begin
         wake_reg <= 1'b1;
      end else if (!flag_reg && state_reg != ST_ADDR_ACK) begin
         wake_reg <= 1'b0;
      end
   end

   // Register bus: one wait state on every transfer.
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         dp_active_reg <= 1'b0;
         dp_done_reg <= 1'b0;
         req_reg <= '0;
      end else begin
         if (i_hsel && i_htrans[1] && i_hready) begin
            dp_active_reg <= 1'b1;
            dp_done_reg <= 1'b0;
            req_reg <= '{write: i_hwrite, offset: i_haddr[7:0]};
         end else if (dp_active_reg && !dp_done_reg) begin
            dp_done_reg <= 1'b1;
         end else if (dp_done_reg) begin
            dp_active_reg <= 1'b0;
            dp_done_reg <= 1'b0;
         end
      end
   end

   assign bus_wr = dp_active_reg & ~dp_done_reg & req_reg.write;
   assign wbyte = i_hwdata[7:0];
   assign flag_clear = bus_wr & (req_reg.offset == `TWS_OFF_CONTROL) & wbyte[`TWS_BIT_FLAG];

   // Read data captured in the wait cycle; unmapped words read zero.
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rdata_reg <= 32'h00000000;
      end else if (dp_active_reg && !dp_done_reg) begin
         unique case (req_reg.offset)
            `TWS_OFF_CONTROL: rdata_reg <= {24'h000000, flag_reg, ctrl_reg.ack_enable, ctrl_reg.start_request,
                                            ctrl_reg.stop_request, wcol_reg, ctrl_reg.iface_enable, 1'b0,
                                            ctrl_reg.iface_irq_enable};
            `TWS_OFF_STATUS: rdata_reg <= {24'h000000, code_reg[7:3], 1'b0, presc_reg};
            `TWS_OFF_DATA: rdata_reg <= {24'h000000, data_reg};
            `TWS_OFF_OWN_ADDR: rdata_reg <= {24'h000000, own_reg};
            default: rdata_reg <= 32'h00000000;
         endcase
      end
   end

   // Control fields, prescaler, own address and data written by software.
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ctrl_reg <= '0;
         presc_reg <= `TWS_RST_PRESC;
         own_reg <= `TWS_RST_OWN_ADDR;
         data_reg <= `TWS_RST_DATA;
      end else if (bus_wr) begin
         unique case (req_reg.offset)
            `TWS_OFF_CONTROL: ctrl_reg <= '{ack_enable: wbyte[`TWS_BIT_ACK_EN], start_request: wbyte[`TWS_BIT_START],
                                            stop_request: wbyte[`TWS_BIT_STOP], iface_enable: wbyte[`TWS_BIT_EN],
                                            iface_irq_enable: wbyte[`TWS_BIT_IRQ_EN]};
            `TWS_OFF_STATUS: presc_reg <= wbyte[1:0];
            `TWS_OFF_OWN_ADDR: own_reg <= wbyte;
            `TWS_OFF_DATA: begin
               if (flag_reg) begin
                  data_reg <= wbyte;
               end
            end
            default: ;
         endcase
      end
   end

   // Flag, status code and write collision; a hardware set wins over a clear.
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         flag_reg <= 1'b0;
         code_reg <= `TWS_ST_NO_INFO;
         wcol_reg <= 1'b0;
      end else begin
         if (set_evt) begin
            flag_reg <= 1'b1;
            code_reg <= set_code;
         end else if (flag_clear) begin
            flag_reg <= 1'b0;
            code_reg <= `TWS_ST_NO_INFO;
         end
         if (bus_wr && req_reg.offset == `TWS_OFF_DATA) begin
            wcol_reg <= ~flag_reg;
         end
      end
   end

   // Pins: only ever pull low; release reads as one on the wire.
   assign o_scl_out = 1'b0;
   assign o_sda_out = 1'b0;
   assign o_scl_oe_n = ~(ctrl_reg.iface_enable & (state_reg == ST_TX_HOLD));
   assign o_sda_oe_n = ~sda_drive_reg;
   assign o_wake = wake_reg;
   assign o_start_request = ctrl_reg.start_request & ctrl_reg.iface_enable & bus_free_reg &
                            ((state_reg == ST_IDLE) | (state_reg == ST_IGNORE));
   assign o_hrdata = rdata_reg;
   assign o_hreadyout = ~dp_active_reg | dp_done_reg;
   assign o_hresp = 1'b0;
endmodule : tws_slave_tx

// File: tws_defines.svh
// Register offsets, field positions, reset values and status codes of the two-wire slave transmitter.
`ifndef TWS_DEFINES_SVH
`define TWS_DEFINES_SVH
// Byte offsets of the word registers on the register bus.
`define TWS_OFF_CONTROL 8'h00
`define TWS_OFF_STATUS 8'h04
`define TWS_OFF_DATA 8'h08
`define TWS_OFF_OWN_ADDR 8'h0c
// Bit positions inside the control register.
`define TWS_BIT_FLAG 7
`define TWS_BIT_ACK_EN 6
`define TWS_BIT_START 5
`define TWS_BIT_STOP 4
`define TWS_BIT_WCOL 3
`define TWS_BIT_EN 2
`define TWS_BIT_IRQ_EN 0
// Reset values of the registers.
`define TWS_RST_CONTROL 8'h00
`define TWS_RST_DATA 8'hff
`define TWS_RST_OWN_ADDR 8'hfe
`define TWS_RST_PRESC 2'h0
// Status codes, prescaler bits excluded.
`define TWS_ST_SLA_R_ACK 8'ha8
`define TWS_ST_ARB_SLA_R 8'hb0
`define TWS_ST_DATA_ACK 8'hb8
`define TWS_ST_DATA_NACK 8'hc0
`define TWS_ST_LAST_ACK 8'hc8
`define TWS_ST_NO_INFO 8'hf8
// Bit counts of one byte on the wire.
`define TWS_BYTE_LAST 4'h7
`define TWS_ADDR_BITS 4'h8
`endif

// File: tws_pkg.sv
// Types shared by the two-wire slave transmitter.
package tws_pkg;
   // Bus-side state of the serial engine.
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_ADDR_ACK = 3'b010,
      ST_TX_HOLD = 3'b011,
      ST_TX_BITS = 3'b100,
      ST_TX_ACK = 3'b101,
      ST_END_HOLD = 3'b110,
      ST_IGNORE = 3'b111
   } tws_state_type;
   // Software-owned control fields.
   typedef struct packed {
      logic ack_enable;
      logic start_request;
      logic stop_request;
      logic iface_enable;
      logic iface_irq_enable;
   } tws_ctrl_type;
   // Register bus request captured in the address phase.
   typedef struct packed {
      logic write;
      logic [7:0] offset;
   } tws_req_type;
endpackage : tws_pkg

// File: tws_bus_master.sv
// Behavioural master receiver that drives the two-wire bus beside the slave.
module tws_bus_master (
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_scl_low,
   output logic o_sda_low
);
   timeunit 1ns;
   timeprecision 1ns;
   // Both lines are released at start, so the pull-ups hold them high.
   initial begin
      o_scl_low = 1'b0;
      o_sda_low = 1'b0;
   end
   // SDA falls while SCL is high, then SCL falls.
   task automatic start_cond;
      o_sda_low = 1'b1;
      #200 o_scl_low = 1'b1;
   endtask : start_cond
   // SDA rises while SCL is high, then the clock stands still.
   task automatic stop_cond;
      #100 o_sda_low = 1'b1;
      #150 o_scl_low = 1'b0;
      #100 o_sda_low = 1'b0;
      #200;
   endtask : stop_cond
   // One bit of 400 ns; a stretched SCL is waited for, within a bound.
   task automatic clk_bit(input logic b, output logic r);
      int n;
      n = 0;
      #100 o_sda_low = ~b;
      #150 o_scl_low = 1'b0;
      while (i_scl !== 1'b1 && n < 20000) begin
         #10 n++;
      end
      #75 r = i_sda;
      #75 o_scl_low = 1'b1;
   endtask : clk_bit
   // Eight bits, most significant first.
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) clk_bit(tx[i], rx[i]);
   endtask : xfer
endmodule : tws_bus_master

// File: tws_slave_tx_chk.sv
// Concurrent checks on the ports of the two-wire slave transmitter.
`include "tws_defines.svh"
module tws_slave_tx_chk (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   input wire logic [31:0] o_hrdata,
   input wire logic o_hreadyout,
   input wire logic o_hresp,
   input wire logic i_scl,
   input wire logic o_scl_out,
   input wire logic o_scl_oe_n,
   input wire logic o_sda_out,
   input wire logic o_sda_oe_n,
   input wire logic i_sleep,
   input wire logic o_wake,
   input wire logic o_start_request
);
   import tws_pkg::*;
   logic ctl_wr_reg; // A control write is in its data phase.
   logic release_ok; // This edge applies a flag clear or a disable.
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   // Track control writes so that any release of SCL can be traced to one.
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ctl_wr_reg <= 1'b0;
      end else if (i_hready) begin
         ctl_wr_reg <= i_hsel & i_htrans[1] & i_hwrite & (i_haddr[7:0] == `TWS_OFF_CONTROL);
      end
   end
   assign release_ok = ctl_wr_reg & ~o_hreadyout & (i_hwdata[`TWS_BIT_FLAG] | ~i_hwdata[`TWS_BIT_EN]);
   a_resp_okay: assert property (o_hresp == 1'b0) else $error("bus response not okay");
   a_wait_once: assert property (i_hsel && i_htrans[1] && i_hready |=> !o_hreadyout ##1 o_hreadyout)
      else $error("wait state not exactly one cycle");
   a_wait_cause: assert property ($fell(o_hreadyout) |-> $past(i_hsel && i_htrans[1] && i_hready))
      else $error("wait state without a transfer");
   a_rdata_hold: assert property (o_hreadyout && $past(o_hreadyout) |-> $stable(o_hrdata))
      else $error("read data moved outside a transfer");
   a_release_cause: assert property ($rose(o_scl_oe_n) |-> $past(release_ok) || $past(release_ok, 2))
      else $error("clock stretch ended without a flag clear");
   a_stretch_sda_free: assert property (!o_scl_oe_n && $past(!o_scl_oe_n) |-> o_sda_oe_n)
      else $error("data line driven while stretching");
   a_sda_scl_low: assert property ($changed(o_sda_oe_n) |-> $past(!i_scl) || $rose(o_scl_oe_n))
      else $error("data line changed while clock high");
   a_wake_sleep: assert property ($rose(o_wake) |-> $past(i_sleep))
      else $error("wake raised while awake");
   a_start_idle: assert property (o_start_request |-> o_scl_oe_n && o_sda_oe_n)
      else $error("start request while addressed");
   a_open_drain: assert property (o_scl_out == 1'b0 && o_sda_out == 1'b0)
      else $error("open drain level not low");
endmodule : tws_slave_tx_chk
bind tws_slave_tx tws_slave_tx_chk tws_slave_tx_chk_i (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel),
   .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
   .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_scl(i_scl), .o_scl_out(o_scl_out),
   .o_scl_oe_n(o_scl_oe_n), .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n), .i_sleep(i_sleep), .o_wake(o_wake),
   .o_start_request(o_start_request));

// File: tws_slave_tx_bench.sv
// Self-checking bench of the two-wire slave transmitter.
`include "tws_defines.svh"
module tws_slave_tx_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import tws_pkg::*;
   logic i_clock = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [1:0] i_htrans = 2'h0;
   logic [31:0] i_haddr = 32'h0;
   logic [31:0] i_hwdata = 32'h0;
   logic i_hwrite = 1'b0;
   logic i_sleep = 1'b0;
   logic i_arb_lost = 1'b0;
   logic [31:0] o_hrdata;
   logic o_hreadyout, o_hresp, o_scl_oe_n, o_sda_oe_n, o_wake, o_start_request;
   logic scl_low, sda_low; // Lines pulled low by the bus master.
   wire scl = ~(scl_low | ~o_scl_oe_n); // Pulled up unless someone drives it.
   wire sda = ~(sda_low | ~o_sda_oe_n); // Pulled up unless someone drives it.
   int errors = 0;
   int n_compared = 0;
   logic [6:0] own; // Random own address.
   logic [7:0] q[$]; // Bytes loaded by software, in send order.
   // Clock of 50 ns.
   always #25 i_clock = ~i_clock;
   tws_slave_tx tws_slave_tx_i (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_hsel(1'b1), .i_haddr(i_haddr),
      .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
      .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_scl(scl), .o_scl_out(),
      .o_scl_oe_n(o_scl_oe_n), .i_sda(sda), .o_sda_out(), .o_sda_oe_n(o_sda_oe_n), .i_sleep(i_sleep),
      .i_arb_lost(i_arb_lost), .o_wake(o_wake), .o_start_request(o_start_request));
   tws_bus_master tws_bus_master_i (.i_scl(scl), .i_sda(sda), .o_scl_low(scl_low), .o_sda_low(sda_low));
   // Compares one value and counts it.
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %0s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // One single transfer; the answer is awaited, never assumed.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
      i_htrans <= 2'h2;
      i_haddr <= {24'h0, a};
      i_hwrite <= wr;
      do @(posedge i_clock); while (o_hreadyout !== 1'b1);
      i_htrans <= 2'h0;
      i_hwdata <= {24'h0, d};
      do @(posedge i_clock); while (o_hreadyout !== 1'b1);
      r = o_hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask : wr
   // Reads a register and compares its masked value.
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 8'h0, r);
      chk(nm, r & m, e);
   endtask : rchk
   // Polls the control register until the step flag is up.
   task automatic wait_flag;
      logic [31:0] r;
      r = 32'h0;
      for (int n = 0; n < 400 && r[7] !== 1'b1; n++) bus(1'b0, `TWS_OFF_CONTROL, 8'h0, r);
   endtask : wait_flag
   // A read frame of n bytes: software feeds bytes while the master reads them.
   task automatic frame(input logic arb, input logic slp, input int n, input logic last_ack);
      logic [7:0] rx;
      logic ack;
      logic [7:0] d;
      i_arb_lost <= arb;
      i_sleep <= slp;
      fork
         begin
            tws_bus_master_i.start_cond();
            tws_bus_master_i.xfer({own, 1'b1}, rx);
            tws_bus_master_i.clk_bit(1'b1, ack);
            chk("addr ack", ack, 32'h0);
            for (int k = 0; k < n; k++) begin
               tws_bus_master_i.xfer(8'hff, rx);
               chk("data", rx, q.pop_front());
               tws_bus_master_i.clk_bit(k == n - 1 && !last_ack, ack);
            end
            if (last_ack) begin
               tws_bus_master_i.xfer(8'hff, rx);
               chk("ignored", rx, 32'hff);
            end
            tws_bus_master_i.stop_cond();
         end
         begin
            for (int k = 0; k <= n; k++) begin
               wait_flag();
               rchk("status", `TWS_OFF_STATUS, 32'hf8, k == n ? (last_ack ? `TWS_ST_LAST_ACK : `TWS_ST_DATA_NACK) :
                  k > 0 ? `TWS_ST_DATA_ACK : arb ? `TWS_ST_ARB_SLA_R : `TWS_ST_SLA_R_ACK);
               if (k == 0) chk("wake", o_wake, slp);
               if (k < n) begin
                  d = 8'($urandom);
                  q.push_back(d);
                  wr(`TWS_OFF_DATA, d);
               end
               wr(`TWS_OFF_CONTROL, (k < n - 1 || k == n) ? 8'hc4 : 8'h84);
            end
         end
      join
      @(posedge i_clock);
      i_sleep <= 1'b0;
   endtask : frame
   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : stop_test
   // Main sequence of tests.
   initial begin
      logic [7:0] rx;
      logic ack;
      void'($urandom(37));
      repeat (3) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      @(posedge i_clock);
      rchk("control", `TWS_OFF_CONTROL, 32'hffffffff, `TWS_RST_CONTROL);
      rchk("status", `TWS_OFF_STATUS, 32'hffffffff, `TWS_ST_NO_INFO);
      rchk("data", `TWS_OFF_DATA, 32'hffffffff, `TWS_RST_DATA);
      rchk("own addr", `TWS_OFF_OWN_ADDR, 32'hffffffff, `TWS_RST_OWN_ADDR);
      rchk("unmapped", 8'h10, 32'hffffffff, 32'h0);
      wr(`TWS_OFF_STATUS, 8'h03);
      rchk("prescaler", `TWS_OFF_STATUS, 32'hff, 32'hfb);
      $display("test registers done");
      own = 7'($urandom_range(127, 1));
      wr(`TWS_OFF_OWN_ADDR, {own, 1'b0});
      wr(`TWS_OFF_CONTROL, 8'h44);
      wr(`TWS_OFF_DATA, 8'h5a);
      rchk("collision", `TWS_OFF_CONTROL, 32'hff, 32'h4c);
      $display("test collision done");
      frame(1'b0, 1'b0, 3, 1'b0);
      $display("test nack frame done");
      frame(1'b1, 1'b1, 2, 1'b1);
      $display("test arbitration sleep frame done");
      wr(`TWS_OFF_CONTROL, 8'h04);
      tws_bus_master_i.start_cond();
      tws_bus_master_i.xfer({own, 1'b1}, rx);
      tws_bus_master_i.clk_bit(1'b1, ack);
      chk("isolated ack", ack, 32'h1);
      tws_bus_master_i.stop_cond();
      @(posedge i_clock);
      rchk("status", `TWS_OFF_STATUS, 32'hf8, `TWS_ST_NO_INFO);
      wr(`TWS_OFF_CONTROL, 8'h64);
      chk("start request", o_start_request, 32'h1);
      $display("test isolation start done");
      stop_test();
   end
   // Cuts a hung run short.
   initial begin
      #1000000;
      errors++;
      stop_test();
   end
endmodule : tws_slave_tx_bench
